// ### rtl/csoa_pkg.sv
// Constants, register map and carrier types of the cyclic sync offset and arrival block.
// Assumes a single 250 MHz clock and an APB master with 32-bit data.
package csoa_pkg;

  // ************************************************
  // Clock and timing
  // ************************************************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MS_US = 1000;
  localparam int unsigned MS_CYC = MS_US * CLK_MHZ;

  // ************************************************
  // Register indices; byte address is four times the index
  // ************************************************
  localparam logic [15:0] IDX_POS_OFF = 16'h60b0;
  localparam logic [15:0] IDX_SPD_OFF = 16'h60b1;
  localparam logic [15:0] IDX_TRQ_OFF = 16'h60b2;
  localparam logic [15:0] IDX_WIN = 16'h6067;
  localparam logic [15:0] IDX_ARR_TIME = 16'h6068;
  localparam logic [15:0] IDX_FOL_ERR = 16'h60f4;
  localparam logic [15:0] IDX_CTRL = 16'h0001;
  localparam logic [15:0] IDX_STATUS = 16'h0002;
  localparam logic [15:0] IDX_INT_STAT = 16'h0003;
  localparam logic [15:0] IDX_INT_EN = 16'h0004;
  localparam logic [15:0] IDX_INT_CLR = 16'h0005;

  // ************************************************
  // Reset values and limits
  // ************************************************
  localparam logic [31:0] RST_W32 = 32'h0000_0000;
  localparam logic [15:0] RST_W16 = 16'h0000;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [2:0] RST_INT = 3'h0;
  localparam logic [31:0] NEG_LIM32 = 32'h8000_0000;
  localparam logic [15:0] NEG_LIM16 = 16'h8000;

  // ************************************************
  // Fields
  // ************************************************
  localparam int unsigned STAT_ARRIVED_BIT = 10;
  localparam int unsigned INT_RISE_BIT = 0;
  localparam int unsigned INT_FALL_BIT = 1;
  localparam int unsigned INT_REFUSE_BIT = 2;
  localparam int unsigned INT_W = 3;

  // ************************************************
  // Operating modes
  // ************************************************
  typedef enum logic [7:0] {
    CSOA_MODE_NONE = 8'h00,
    CSOA_MODE_CSP = 8'h08,
    CSOA_MODE_CSV = 8'h09,
    CSOA_MODE_CST = 8'h0a
  } csoa_mode_t;

  // ************************************************
  // Carriers
  // ************************************************
  typedef struct packed {
    logic valid;
    logic [31:0] pos;
    logic [31:0] spd;
  } csoa_cyc_t;

  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] spd;
    logic [15:0] trq;
  } csoa_cmd_t;

endpackage

// ### rtl/csoa_dwell.sv
// Arrival dwell timer: counts whole milliseconds spent inside the window.
// Assumes restart is a level from logic on the same clock.
`timescale 1ns/1ns
module csoa_dwell
  import csoa_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic restart,
  input wire logic [15:0] thr_ms,
  // Result
  output logic arrived
);

  // ************************************************
  // Millisecond prescaler
  // ************************************************
  logic [31:0] pre_r;
  logic [16:0] ms_r;
  wire logic ms_tick;
  wire logic ms_full;

  assign ms_tick = (pre_r == 32'(MS_CYCLES - 1));
  // Saturate one past the largest threshold so "longer than" stays true
  assign ms_full = ms_r[16];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= RST_W32;
    end else if (restart || ms_tick) begin
      pre_r <= RST_W32;
    end else begin
      pre_r <= pre_r + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ms_r <= 17'h0;
    end else if (restart) begin
      ms_r <= 17'h0;
    end else if (ms_tick && !ms_full) begin
      ms_r <= ms_r + 17'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arrived <= 1'b0;
    end else if (restart) begin
      arrived <= 1'b0;
    end else begin
      arrived <= (ms_r > {1'b0, thr_ms});
    end
  end

endmodule

// ### rtl/csoa_top.sv
// Offset registers, command summing, following error and arrival flag.
// Assumes cyclic targets, feedback and the run level come from logic on pclk.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
module csoa_top
  import csoa_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Cyclic targets from the fieldbus side
  input wire csoa_cyc_t cyc_in,
  // Drive feedback
  input wire logic [31:0] act_pos,
  input wire logic drive_running,
  // Commands to the control loops
  output csoa_cmd_t cmd_out,
  output logic [15:0] status_word,
  // Interrupt
  output logic irq
);

  // ************************************************
  // Registers
  // ************************************************
  logic [31:0] pos_off_r;
  logic [31:0] spd_off_r;
  logic [15:0] trq_off_r;
  logic [31:0] win_r;
  logic [15:0] arr_time_r;
  logic [31:0] fol_err_r;
  logic [7:0] mode_r;
  logic [31:0] pos_cmd_r;
  logic [31:0] spd_cmd_r;
  logic [INT_W-1:0] int_stat_r;
  logic [INT_W-1:0] int_en_r;
  logic [31:0] prdata_r;
  logic arrived_d_r;
  logic arrived;

  // ************************************************
  // Address decode
  // ************************************************
  wire logic [15:0] idx;
  wire logic word_ok;
  wire logic setup;
  wire logic acc;
  wire logic wr;

  assign idx = paddr[17:2];
  assign word_ok = (paddr[1:0] == 2'b00);
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite;

  wire logic hit_pos;
  wire logic hit_spd;
  wire logic hit_trq;
  wire logic hit_win;
  wire logic hit_time;
  wire logic hit_err;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic hit_ist;
  wire logic hit_ien;
  wire logic hit_icl;
  wire logic mapped;

  assign hit_pos = word_ok && (idx == IDX_POS_OFF);
  assign hit_spd = word_ok && (idx == IDX_SPD_OFF);
  assign hit_trq = word_ok && (idx == IDX_TRQ_OFF);
  assign hit_win = word_ok && (idx == IDX_WIN);
  assign hit_time = word_ok && (idx == IDX_ARR_TIME);
  assign hit_err = word_ok && (idx == IDX_FOL_ERR);
  assign hit_ctrl = word_ok && (idx == IDX_CTRL);
  assign hit_stat = word_ok && (idx == IDX_STATUS);
  assign hit_ist = word_ok && (idx == IDX_INT_STAT);
  assign hit_ien = word_ok && (idx == IDX_INT_EN);
  assign hit_icl = word_ok && (idx == IDX_INT_CLR);
  assign mapped = hit_pos || hit_spd || hit_trq || hit_win || hit_time || hit_err
    || hit_ctrl || hit_stat || hit_ist || hit_ien || hit_icl;

  // ************************************************
  // Range checks and refusals
  // ************************************************
  // position, speed and torque range
  wire logic bad_pos;
  wire logic bad_spd;
  wire logic bad_trq;
  wire logic ro_hit;
  wire logic refuse;

  assign bad_pos = hit_pos && (pwdata == NEG_LIM32);
  assign bad_spd = hit_spd && (pwdata == NEG_LIM32);
  assign bad_trq = hit_trq && (pwdata[15:0] == NEG_LIM16);
  // Read-only words refuse writes rather than silently dropping them
  assign ro_hit = hit_err || hit_stat || hit_ist;
  assign refuse = !mapped || (pwrite && (bad_pos || bad_spd || bad_trq || ro_hit))
    || (!pwrite && hit_icl);

  wire logic wr_ok;
  assign wr_ok = wr && !refuse;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = acc && refuse;

  // ************************************************
  // Software registers
  // ************************************************
  // position offset store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_off_r <= RST_W32;
    end else if (wr_ok && hit_pos) begin
      pos_off_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spd_off_r <= RST_W32;
    end else if (wr_ok && hit_spd) begin
      spd_off_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trq_off_r <= RST_W16;
    end else if (wr_ok && hit_trq) begin
      trq_off_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r <= RST_W32;
      arr_time_r <= RST_W16;
    end else begin
      if (wr_ok && hit_win) begin
        win_r <= pwdata;
      end
      if (wr_ok && hit_time) begin
        arr_time_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= RST_MODE;
    end else if (wr_ok && hit_ctrl) begin
      mode_r <= pwdata[7:0];
    end
  end

  // ************************************************
  // Command summing
  // ************************************************
  wire logic csp;
  wire logic csv;
  wire logic [31:0] pos_sum;
  wire logic [31:0] spd_sum;

  assign csp = (mode_r == CSOA_MODE_CSP);
  assign csv = (mode_r == CSOA_MODE_CSV);
  assign pos_sum = cyc_in.pos + pos_off_r;
  assign spd_sum = cyc_in.spd + spd_off_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_cmd_r <= RST_W32;
    end else if (csp && cyc_in.valid) begin
      pos_cmd_r <= pos_sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spd_cmd_r <= RST_W32;
    end else if (csv && cyc_in.valid) begin
      spd_cmd_r <= spd_sum;
    end
  end

  assign cmd_out.pos = pos_cmd_r;
  assign cmd_out.spd = spd_cmd_r;
  assign cmd_out.trq = trq_off_r;

  // ************************************************
  // Following error and arrival
  // ************************************************
  wire logic [31:0] err_now;
  wire logic [31:0] err_mag;
  wire logic in_win;
  wire logic restart;

  assign err_now = pos_cmd_r - act_pos;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fol_err_r <= RST_W32;
    end else begin
      fol_err_r <= err_now;
    end
  end

  assign err_mag = fol_err_r[31] ? (~fol_err_r + 32'h1) : fol_err_r;
  assign in_win = (err_mag < win_r);
  assign restart = !in_win || !drive_running;

  // A millisecond prescaler is long; the parameter lets simulation shorten it
  csoa_dwell #(
    .MS_CYCLES(MS_CYCLES)
  ) u_dwell (
    .clk(pclk),
    .rstn(presetn),
    .restart(restart),
    .thr_ms(arr_time_r),
    .arrived(arrived)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arrived_d_r <= 1'b0;
    end else begin
      arrived_d_r <= arrived && drive_running;
    end
  end

  // Bit 10 only; other status bits belong to the drive state machine
  assign status_word = {5'h00, arrived_d_r, 10'h000};

  // ************************************************
  // Interrupts
  // ************************************************
  wire logic [INT_W-1:0] ev;
  wire logic [INT_W-1:0] clr;

  assign ev[INT_RISE_BIT] = arrived && drive_running && !arrived_d_r;
  assign ev[INT_FALL_BIT] = !(arrived && drive_running) && arrived_d_r;
  assign ev[INT_REFUSE_BIT] = acc && refuse;
  assign clr = (wr_ok && hit_icl) ? pwdata[INT_W-1:0] : RST_INT;

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= RST_INT;
    end else begin
      int_stat_r <= (int_stat_r & ~clr) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_r <= RST_INT;
    end else if (wr_ok && hit_ien) begin
      int_en_r <= pwdata[INT_W-1:0];
    end
  end

  assign irq = |(int_stat_r & int_en_r);

  // ************************************************
  // Read data
  // ************************************************
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = RST_W32;
    if (hit_pos) begin
      rd_nxt = pos_off_r;
    end else if (hit_spd) begin
      rd_nxt = spd_off_r;
    end else if (hit_trq) begin
      rd_nxt = {{16{trq_off_r[15]}}, trq_off_r};
    end else if (hit_win) begin
      rd_nxt = win_r;
    end else if (hit_time) begin
      rd_nxt = {16'h0000, arr_time_r};
    end else if (hit_err) begin
      rd_nxt = fol_err_r;
    end else if (hit_ctrl) begin
      rd_nxt = {24'h000000, mode_r};
    end else if (hit_stat) begin
      rd_nxt = {16'h0000, status_word};
    end else if (hit_ist) begin
      rd_nxt = {29'h0, int_stat_r};
    end else if (hit_ien) begin
      rd_nxt = {29'h0, int_en_r};
    end
  end

  // Captured in the setup cycle so prdata is a flop during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= RST_W32;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_nxt;
    end
  end

  assign prdata = prdata_r;

endmodule

// ### verif/csoa_ctrl_model.sv
// Motion controller model sending cyclic targets.
// Assumes the bench sets enable and base targets on pclk.
`timescale 1ns/1ns
module csoa_ctrl_model
  import csoa_pkg::*;
#(
  parameter int unsigned PERIOD = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic en,
  input wire logic [31:0] base_pos,
  input wire logic [31:0] base_spd,
  // Toward the drive
  output csoa_cyc_t cyc
);
  logic [31:0] cnt_r;
  logic [31:0] seq_r;
  // fresh target each cycle
  // Speed moves every cycle so a stale sum shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0;
      seq_r <= 32'h0;
      cyc <= 65'h0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 32'h0 : cnt_r + 32'h1;
      cyc.valid <= en && cnt_r == 32'h0;
      if (en && cnt_r == 32'h0) begin
        seq_r <= seq_r + 32'h1;
        cyc.pos <= base_pos;
        cyc.spd <= base_spd + seq_r;
      end else begin
        // Lines outside a frame never repeat the last value
        cyc.pos <= ~cyc.pos;
        cyc.spd <= ~cyc.spd;
      end
    end
  end
endmodule

// ### verif/csoa_top_properties.sv
// Port checker of csoa_top.
// Assumes the bind at the foot of this file.
`timescale 1ns/1ns
module csoa_props
  import csoa_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Drive side
  input wire csoa_cyc_t cyc_in,
  input wire logic [31:0] act_pos,
  input wire logic drive_running,
  input wire csoa_cmd_t cmd_out,
  input wire logic [15:0] status_word,
  input wire logic irq
);
  wire logic acc = psel && penable;
  wire logic wr_ok = acc && pwrite && !pslverr;
  wire logic [15:0] ix = paddr[17:2];
  logic [31:0] pos_r, spd_r, run_r;
  logic [15:0] thr_r;
  logic [7:0] mode_r;
  // Shadows follow accepted writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r <= 32'h0;
      spd_r <= 32'h0;
      run_r <= 32'h0;
      thr_r <= 16'h0;
      mode_r <= 8'h0;
    end else begin
      run_r <= drive_running ? run_r + 32'h1 : 32'h0;
      if (wr_ok && ix == IDX_POS_OFF) pos_r <= pwdata;
      if (wr_ok && ix == IDX_SPD_OFF) spd_r <= pwdata;
      if (wr_ok && ix == IDX_ARR_TIME) thr_r <= pwdata[15:0];
      if (wr_ok && ix == IDX_CTRL) mode_r <= pwdata[7:0];
    end
  end
  // ****
  // Checks
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_spd; cyc_in.valid && mode_r == CSOA_MODE_CSV
    |=> cmd_out.spd == $past(cyc_in.spd) + $past(spd_r); endproperty
  a_spd: assert property (p_spd) else $error("speed sum wrong");
  property p_pos; cyc_in.valid && mode_r == CSOA_MODE_CSP
    |=> cmd_out.pos == $past(cyc_in.pos) + $past(pos_r); endproperty
  a_pos: assert property (p_pos) else $error("position sum wrong");
  property p_hold; !cyc_in.valid |=> $stable(cmd_out.spd) && $stable(cmd_out.pos); endproperty
  a_hold: assert property (p_hold) else $error("command moved");
  property p_trq; wr_ok && ix == IDX_TRQ_OFF |=> cmd_out.trq == $past(pwdata[15:0]); endproperty
  a_trq: assert property (p_trq) else $error("torque offset wrong");
  property p_lim; acc && pwrite && (ix == IDX_POS_OFF || ix == IDX_SPD_OFF) && pwdata == NEG_LIM32
    |-> pslverr; endproperty
  a_lim: assert property (p_lim) else $error("offset range");
  property p_ro; acc && pwrite && ix == IDX_FOL_ERR |-> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("error register written");
  property p_rise; $rose(status_word[10]) |-> run_r >= (thr_r + 32'h1) * MS_CYCLES; endproperty
  a_rise: assert property (p_rise) else $error("arrival too early");
  property p_stop; !drive_running [*3] |-> !status_word[10]; endproperty
  a_stop: assert property (p_stop) else $error("arrival while stopped");
  c_spd: cover property (cyc_in.valid && mode_r == CSOA_MODE_CSV);
  c_arr: cover property ($rose(status_word[10]));
  c_err: cover property (acc && pslverr);
endmodule
bind csoa_top csoa_props #(.MS_CYCLES(MS_CYCLES)) csoa_props_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cyc_in(cyc_in), .act_pos(act_pos), .drive_running(drive_running),
  .cmd_out(cmd_out), .status_word(status_word), .irq(irq));

// ### verif/tb_cyclic_sync_offset_arrival.sv
// Bench of csoa_top with a cyclic target model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; $display("Error %0t: mismatch", $time); end end
module tb_cyclic_sync_offset_arrival;
  import csoa_pkg::*;
  // Short millisecond keeps arrival waits small
  localparam int unsigned MSC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic drive_running = 1'b0;
  logic en = 1'b0;
  logic e = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] act_pos = 32'h0;
  logic [31:0] base_pos = 32'h0;
  logic [31:0] base_spd = 32'h0;
  logic [31:0] rd = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [15:0] status_word;
  csoa_cyc_t cyc_in;
  csoa_cmd_t cmd_out;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc_n = 0;
  always #2 pclk = ~pclk;
  csoa_top #(.MS_CYCLES(MSC)) csoa_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cyc_in(cyc_in), .act_pos(act_pos), .drive_running(drive_running), .cmd_out(cmd_out),
    .status_word(status_word), .irq(irq));
  csoa_ctrl_model #(.PERIOD(8)) csoa_ctrl_model_inst (.pclk(pclk), .presetn(presetn), .en(en),
    .base_pos(base_pos), .base_spd(base_spd), .cyc(cyc_in));
  // ****
  // Tasks
  // ****
  task automatic print_verdict;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] ix, input logic [31:0] d, input logic xe);
    apb(1'b1, {ix, 2'b00}, d);
    `CHK(e, xe)
  endtask
  task automatic rdc(input logic [15:0] ix, input logic [31:0] x);
    apb(1'b0, {ix, 2'b00}, 32'h0);
    `CHK(rd, x)
  endtask
  task automatic next_cmd(output logic [31:0] p, output logic [31:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    while (cyc_in.valid !== 1'b1 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    p = cyc_in.pos;
    s = cyc_in.spd;
    @(posedge pclk);
  endtask
  task automatic t_reset;
    logic [15:0] ix [6];
    ix = '{IDX_POS_OFF, IDX_SPD_OFF, IDX_TRQ_OFF, IDX_WIN, IDX_ARR_TIME, IDX_FOL_ERR};
    foreach (ix[i]) rdc(ix[i], 32'h0);
    `CHK(cmd_out, 80'h0)
  endtask
  task automatic t_regs;
    wr(IDX_POS_OFF, 32'h7fff_ffff, 1'b0);
    wr(IDX_POS_OFF, NEG_LIM32, 1'b1);
    rdc(IDX_POS_OFF, 32'h7fff_ffff);
    wr(IDX_SPD_OFF, 32'h8000_0001, 1'b0);
    wr(IDX_SPD_OFF, NEG_LIM32, 1'b1);
    rdc(IDX_SPD_OFF, 32'h8000_0001);
    wr(IDX_TRQ_OFF, 32'hffff_8001, 1'b0);
    wr(IDX_TRQ_OFF, 32'h0000_8000, 1'b1);
    rdc(IDX_TRQ_OFF, 32'hffff_8001);
    `CHK(cmd_out.trq, 16'h8001)
    wr(IDX_WIN, 32'hffff_ffff, 1'b0);
    rdc(IDX_WIN, 32'hffff_ffff);
    wr(IDX_ARR_TIME, 32'h1234_ffff, 1'b0);
    rdc(IDX_ARR_TIME, 32'h0000_ffff);
    wr(IDX_FOL_ERR, 32'h0000_0001, 1'b1);
    rdc(IDX_FOL_ERR, 32'h0);
  endtask
  task automatic t_irq;
    wr(IDX_INT_CLR, 32'h0000_0007, 1'b0);
    wr(IDX_INT_EN, 32'h0, 1'b0);
    apb(1'b0, 18'h00400, 32'h0);
    `CHK(e, 1'b1)
    // Reading the write-only clear word and writing a misaligned address are refused too
    apb(1'b0, {IDX_INT_CLR, 2'b00}, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b1, {IDX_WIN, 2'b10}, 32'h0000_0005);
    `CHK(e, 1'b1)
    rdc(IDX_INT_STAT, 32'h0000_0004);
    `CHK(irq, 1'b0)
    wr(IDX_INT_EN, 32'h0000_0004, 1'b0);
    `CHK(irq, 1'b1)
    wr(IDX_INT_CLR, 32'h0000_0004, 1'b0);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_speed;
    logic [31:0] p, s;
    wr(IDX_CTRL, 32'h0000_0009, 1'b0);
    wr(IDX_SPD_OFF, 32'h0000_0100, 1'b0);
    base_pos <= 32'h0000_0055;
    base_spd <= 32'hffff_ff00;
    en <= 1'b1;
    repeat (3) begin
      next_cmd(p, s);
      `CHK(cmd_out.spd, s + 32'h0000_0100)
      `CHK(cmd_out.pos, 32'h0)
    end
    wr(IDX_CTRL, 32'h0000_0008, 1'b0);
    wr(IDX_POS_OFF, 32'hffff_fff6, 1'b0);
    next_cmd(p, s);
    `CHK(cmd_out.pos, p + 32'hffff_fff6)
  endtask
  task automatic t_arrive;
    int t0;
    wr(IDX_WIN, 32'h0000_000b, 1'b0);
    wr(IDX_ARR_TIME, 32'h0000_0002, 1'b0);
    act_pos <= 32'h0000_0041;
    drive_running <= 1'b1;
    t0 = cyc_n;
    // Error register lags the feedback by one edge; read data is taken at setup
    repeat (2) @(posedge pclk);
    rdc(IDX_FOL_ERR, 32'h0000_000a);
    while (status_word[10] !== 1'b1 && cyc_n - t0 < 100) @(posedge pclk);
    `CHK(cyc_n - t0 >= 3 * MSC && cyc_n - t0 <= 3 * MSC + 8, 1'b1)
    act_pos <= 32'h0000_0040;
    repeat (4) @(posedge pclk);
    `CHK(status_word[10], 1'b0)
    act_pos <= 32'h0000_0055;
    repeat (3 * MSC + 8) @(posedge pclk);
    `CHK(status_word[10], 1'b1)
    rdc(IDX_FOL_ERR, 32'hffff_fff6);
    drive_running <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(status_word[10], 1'b0)
    // Both arrival edges were seen, so rise and fall flags are sticky
    rdc(IDX_INT_STAT, 32'h0000_0003);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_regs;
    t_irq;
    t_speed;
    t_arrive;
    print_verdict;
  end
endmodule
